// *** design/bcd_clock_regs.svh ***
// offsets, field positions, reset values and timing figures of the clock
// assumes inclusion by bare name from the clock register file module
`ifndef BCD_CLOCK_REGS_SVH
`define BCD_CLOCK_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_RTC_CONTROL 8'h00
`define OFF_HOUR_FORMAT_MODE 8'h04
`define OFF_TIME_OF_DAY 8'h08
`define OFF_CALENDAR_DATE 8'h0c
`define OFF_TIME_ALARM 8'h10
`define OFF_CALENDAR_ALARM 8'h14
`define OFF_EVENT_STATUS 8'h18
`define OFF_STATUS_CLEAR_COMMAND 8'h1c
`define OFF_IRQ_ENABLE_SET 8'h20
`define OFF_IRQ_ENABLE_CLEAR 8'h24
`define OFF_IRQ_MASK_STATE 8'h28
`define OFF_ENTRY_VALIDITY 8'h2c
`define OFF_RESERVED_SLOT 8'hfc

// ****************************************
// fields and masks of significant bits
// ****************************************
`define CTRL_MASK 32'h00030303
`define MODE_MASK 32'h00000001
`define TIME_MASK 32'h007f7f7f
`define CAL_MASK 32'h3fffff7f
`define TALM_MASK 32'h00ffffff
`define CALM_MASK 32'hbf9f0000
`define CAL_RESET 32'h01819819
`define CALM_RESET 32'h01010000
`define ST_ACK 0
`define ST_ALARM 1
`define ST_SEC 2
`define ST_TIME_EVENT_FLAG 3
`define ST_CALENDAR_EVENT_FLAG 4

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 10
`define ONE_SECOND_NS 1000000000

`endif

// *** design/bcd_clock_pkg.sv ***
// types and bcd helpers shared by the clock modules
// assumes the register header sits beside it
package bcd_clock_pkg;
    // update acknowledge sequencing
    typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT, UPD_GRANT} upd_e;

    // digit-wise check and range check, valid for packed bcd
    function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction

    // bcd increment by one
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // every year divisible by four is a leap year
    function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction
endpackage

// *** design/second_tick.sv ***
// one-second tick from the bus clock
// assumes a free-running clock at the rate given by the period macro
`timescale 1ns/1ns
module second_tick
    import bcd_clock_pkg::*;
#(
    parameter int CYCLES = 100000000
) (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    output logic tick // one-cycle pulse each second
);
    logic [31:0] cnt_q;

    // free counter, wraps once a second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == 32'(CYCLES - 1));
            cnt_q <= (cnt_q == 32'(CYCLES - 1)) ? 32'h0 : cnt_q + 32'h1;
        end
    end
endmodule

// *** design/entry_check.sv ***
// combinational entry checks for written time, calendar and alarm words
// assumes the hour format of the mode register as input
`timescale 1ns/1ns
module entry_check
    import bcd_clock_pkg::*;
(
    input wire logic [31:0] wdata, // word being written
    input wire logic hour12, // 12-hour format selected
    output logic time_ok, // time word acceptable
    output logic cal_ok, // calendar word acceptable
    output logic talm_ok, // time alarm word acceptable
    output logic calm_ok // calendar alarm word acceptable
);
    // hour range follows the format; meridiem must stay 0 in 24-hour
    // format passed in so a mode change alone re-evaluates the checks
    function automatic logic hour_ok(input logic [7:0] h, input logic pm, input logic h12);
        return h12 ? bcd_in(h, 8'h01, 8'h12) : (bcd_in(h, 8'h00, 8'h23) && !pm);
    endfunction

    logic [7:0] month, date;
    assign month = {3'h0, wdata[20:16]};
    assign date = {2'h0, wdata[29:24]};

    assign time_ok = bcd_in({1'b0, wdata[6:0]}, 8'h00, 8'h59) && bcd_in({1'b0, wdata[14:8]}, 8'h00, 8'h59)
        && hour_ok({2'h0, wdata[21:16]}, wdata[22], hour12);
    assign talm_ok = bcd_in({1'b0, wdata[6:0]}, 8'h00, 8'h59) && bcd_in({1'b0, wdata[14:8]}, 8'h00, 8'h59)
        && hour_ok({2'h0, wdata[21:16]}, wdata[22], hour12);
    assign cal_ok = bcd_in({1'b0, wdata[6:0]}, 8'h19, 8'h20) && bcd_in(wdata[15:8], 8'h00, 8'h99)
        && bcd_in(month, 8'h01, 8'h12) && bcd_in({5'h0, wdata[23:21]}, 8'h01, 8'h07)
        && bcd_in(date, 8'h01, days_in_month(month, wdata[15:8]));
    assign calm_ok = bcd_in(month, 8'h01, 8'h12) && bcd_in(date, 8'h01, 8'h31);
endmodule

// *** design/bcd_calendar_clock_regs.sv ***
// bcd time-of-day clock and calendar with its apb register file
// assumes an apb master on pclk; seconds are counted from pclk itself
//
// Contract
// - time update request halts time counting
// - calendar update request halts calendar counting
// - time event select picks minute/hour/midnight/noon
// - calendar event select picks week/month/year
// - mode bit selects 24 or 12-hour
// - unused bits always read zero
// - bcd units low nibble, tens above
// - seconds and minutes accept 0 to 59
// - hours range depends on hour format
// - bit 22 is meridiem, 1 afternoon
// - hundred-years accepts 19 or 20 only
// - year accepts 00 through 99
// - month 01-12, day-of-month 01-31
// - weekday 1-7, no effect on date
// - time alarm fields matched only when enabled
// - month, date alarm compared only when enabled
// - status bit layout ack/alarm/sec/time/calendar
// - clear command ones clear status flags
// - enable sets mask bit, disable clears
// - invalid writes rejected, non-valid flag set
`timescale 1ns/1ns
`include "bcd_clock_regs.svh"
module bcd_calendar_clock_regs
    import bcd_clock_pkg::*;
#(
    parameter int SECOND_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic irq // level interrupt
);
    // ****************************************
    // state
    // ****************************************
    logic time_req_q, cal_req_q, mode_q, tick, tick_d1_q;
    logic [1:0] tsel_q, csel_q;
    logic [31:0] time_q, cal_q, talm_q, calm_q;
    logic [4:0] sr_q, imr_q, sr_set;
    logic [3:0] ver_q;
    upd_e upd_q;

    second_tick #(.CYCLES(SECOND_CYCLES)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // ****************************************
    // apb decode
    // ****************************************
    logic setup, wr, mapped;
    logic [31:0] rd_mux;
    logic time_ok, cal_ok, talm_ok, calm_ok;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    // zero wait states; the error flag is only a hint to the master
    assign pready = 1'b1;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `OFF_ENTRY_VALIDITY || paddr == `OFF_RESERVED_SLOT);
    assign pslverr = psel && penable && !mapped;

    // write strobe for one offset
    function automatic logic wr_at(input logic [7:0] off);
        return wr && (paddr == off);
    endfunction

    entry_check u_check (
        .wdata(pwdata),
        .hour12(mode_q),
        .time_ok(time_ok),
        .cal_ok(cal_ok),
        .talm_ok(talm_ok),
        .calm_ok(calm_ok)
    );

    // read mux, unused bits and write-only registers read zero
    always_comb begin
        case (paddr)
            `OFF_RTC_CONTROL: rd_mux = {14'h0, csel_q, 6'h0, tsel_q, 6'h0, cal_req_q, time_req_q};
            `OFF_HOUR_FORMAT_MODE: rd_mux = {31'h0, mode_q};
            `OFF_TIME_OF_DAY: rd_mux = time_q;
            `OFF_CALENDAR_DATE: rd_mux = cal_q;
            `OFF_TIME_ALARM: rd_mux = talm_q;
            `OFF_CALENDAR_ALARM: rd_mux = calm_q;
            `OFF_EVENT_STATUS: rd_mux = {27'h0, sr_q};
            `OFF_IRQ_MASK_STATE: rd_mux = {27'h0, imr_q};
            `OFF_ENTRY_VALIDITY: rd_mux = {28'h0, ver_q};
            default: rd_mux = 32'h0;
        endcase
    end

    // read data captured in the setup cycle, stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ****************************************
    // control and mode
    // ****************************************
    // hour format and event selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_req_q <= 1'b0;
            cal_req_q <= 1'b0;
            tsel_q <= 2'h0;
            csel_q <= 2'h0;
            mode_q <= 1'b0;
        end else begin
            if (wr_at(`OFF_RTC_CONTROL)) begin
                time_req_q <= pwdata[0];
                cal_req_q <= pwdata[1];
                tsel_q <= pwdata[9:8];
                csel_q <= pwdata[17:16];
            end
            if (wr_at(`OFF_HOUR_FORMAT_MODE)) begin
                mode_q <= pwdata[0];
            end
        end
    end

    // ****************************************
    // time counting
    // ****************************************
    logic run_time, sec_wrap, min_wrap, day_chg, noon, min_ev, hour_ev, mid_ev, noon_ev;
    logic [7:0] hr, hr_n, sec_n, min_n;
    logic pm_n;

    // time halts while its update is requested
    assign run_time = tick && !time_req_q;
    assign sec_wrap = time_q[6:0] == 7'h59;
    assign min_wrap = time_q[14:8] == 7'h59;
    assign hr = {2'h0, time_q[21:16]};
    assign sec_n = bcd_inc({1'b0, time_q[6:0]});
    assign min_n = bcd_inc({1'b0, time_q[14:8]});

    // meridiem flips at 11 to 12; pm to am is the day change
    always_comb begin
        hr_n = bcd_inc(hr);
        pm_n = time_q[22];
        day_chg = 1'b0;
        noon = 1'b0;
        if (mode_q) begin
            if (hr == 8'h11) begin
                pm_n = !time_q[22];
                day_chg = time_q[22];
                noon = !time_q[22];
            end else if (hr == 8'h12) begin
                hr_n = 8'h01;
            end
        end else if (hr == 8'h23) begin
            hr_n = 8'h00;
            day_chg = 1'b1;
        end else begin
            noon = hr == 8'h11;
        end
    end

    assign min_ev = run_time && sec_wrap;
    assign hour_ev = min_ev && min_wrap;
    assign mid_ev = hour_ev && day_chg;
    assign noon_ev = hour_ev && noon;

    // bcd counting of seconds, minutes, hours
    // rejected words leave the counters alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_q <= 32'h0;
        end else if (wr_at(`OFF_TIME_OF_DAY)) begin
            if (time_ok) begin
                time_q <= pwdata & `TIME_MASK;
            end
        end else if (run_time) begin
            time_q[6:0] <= sec_wrap ? 7'h00 : sec_n[6:0];
            if (sec_wrap) begin
                time_q[14:8] <= min_wrap ? 7'h00 : min_n[6:0];
            end
            if (hour_ev) begin
                time_q[21:16] <= hr_n[5:0];
                time_q[22] <= pm_n;
            end
        end
    end

    // ****************************************
    // calendar counting
    // ****************************************
    logic run_cal, date_wrap, month_wrap, week_ev;
    logic [7:0] month, date, hundred_years_field, date_n, month_n;
    logic cal_ev;

    // calendar halts while either update is requested
    assign run_cal = mid_ev && !cal_req_q;
    assign month = {3'h0, cal_q[20:16]};
    assign date = {2'h0, cal_q[29:24]};
    assign hundred_years_field = {1'b0, cal_q[6:0]};
    assign date_n = bcd_inc(date);
    assign month_n = bcd_inc(month);
    assign date_wrap = date == days_in_month(month, cal_q[15:8]);
    assign month_wrap = date_wrap && month == 8'h12;
    // weekday code 7 rolls to 1, taken as monday
    assign week_ev = cal_q[23:21] == 3'h7;

    // weekday rolls on its own, date ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_q <= `CAL_RESET;
        end else if (wr_at(`OFF_CALENDAR_DATE)) begin
            if (cal_ok) begin
                cal_q <= pwdata & `CAL_MASK;
            end
        end else if (run_cal) begin
            cal_q[23:21] <= week_ev ? 3'h1 : cal_q[23:21] + 3'h1;
            cal_q[29:24] <= date_wrap ? 6'h01 : date_n[5:0];
            if (date_wrap) begin
                cal_q[20:16] <= month_wrap ? 5'h01 : month_n[4:0];
            end
            if (month_wrap) begin
                cal_q[15:8] <= bcd_inc(cal_q[15:8]);
                if (cal_q[15:8] == 8'h99) begin
                    cal_q[15:8] <= 8'h00;
                    cal_q[6:0] <= (hundred_years_field == 8'h19) ? 7'h20 : 7'h19;
                end
            end
        end
    end

    always_comb begin
        case (csel_q)
            2'h0: cal_ev = run_cal && week_ev;
            2'h1: cal_ev = run_cal && date_wrap;
            default: cal_ev = run_cal && month_wrap;
        endcase
    end

    // ****************************************
    // alarms
    // ****************************************
    logic alarm_hit, talm_any;

    // alarm words also checked before loading
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            talm_q <= 32'h0;
            calm_q <= `CALM_RESET;
        end else begin
            if (wr_at(`OFF_TIME_ALARM) && talm_ok) begin
                talm_q <= pwdata & `TALM_MASK;
            end
            if (wr_at(`OFF_CALENDAR_ALARM) && calm_ok) begin
                calm_q <= pwdata & `CALM_MASK;
            end
        end
    end

    // time fields match only when enabled
    // month and date compared only when enabled
    assign talm_any = talm_q[7] || talm_q[15] || talm_q[23] || calm_q[23] || calm_q[31];
    assign alarm_hit = talm_any
        && (!talm_q[7] || talm_q[6:0] == time_q[6:0])
        && (!talm_q[15] || talm_q[14:8] == time_q[14:8])
        && (!talm_q[23] || talm_q[22:16] == time_q[22:16])
        && (!calm_q[23] || calm_q[20:16] == cal_q[20:16])
        && (!calm_q[31] || calm_q[29:24] == cal_q[29:24]);

    // ****************************************
    // update acknowledge
    // ****************************************
    // the grant waits for a second boundary so counters stop cleanly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_q <= UPD_IDLE;
        end else begin
            case (upd_q)
                UPD_IDLE: upd_q <= (time_req_q || cal_req_q) ? UPD_WAIT : UPD_IDLE;
                UPD_WAIT: upd_q <= !(time_req_q || cal_req_q) ? UPD_IDLE : (tick ? UPD_GRANT : UPD_WAIT);
                UPD_GRANT: upd_q <= (time_req_q || cal_req_q) ? UPD_GRANT : UPD_IDLE;
                default: upd_q <= UPD_IDLE;
            endcase
        end
    end

    // ****************************************
    // status, mask, validity
    // ****************************************
    logic tim_ev;

    always_comb begin
        case (tsel_q)
            2'h0: tim_ev = min_ev;
            2'h1: tim_ev = hour_ev;
            2'h2: tim_ev = mid_ev;
            default: tim_ev = noon_ev;
        endcase
    end

    assign sr_set = {cal_ev, tim_ev, tick, tick_d1_q && alarm_hit,
        upd_q == UPD_WAIT && tick && (time_req_q || cal_req_q)};

    // clear by writing ones; a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= 5'h0;
            tick_d1_q <= 1'b0;
        end else begin
            tick_d1_q <= tick;
            sr_q <= (wr_at(`OFF_STATUS_CLEAR_COMMAND) ? sr_q & ~pwdata[4:0] : sr_q) | sr_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imr_q <= 5'h0;
        end else if (wr_at(`OFF_IRQ_ENABLE_SET)) begin
            imr_q <= imr_q | pwdata[4:0];
        end else if (wr_at(`OFF_IRQ_ENABLE_CLEAR)) begin
            imr_q <= imr_q & ~pwdata[4:0];
        end
    end

    // non-valid flags follow the last write of each word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ver_q <= 4'h0;
        end else begin
            if (wr_at(`OFF_TIME_OF_DAY)) ver_q[0] <= !time_ok;
            if (wr_at(`OFF_CALENDAR_DATE)) ver_q[1] <= !cal_ok;
            if (wr_at(`OFF_TIME_ALARM)) ver_q[2] <= !talm_ok;
            if (wr_at(`OFF_CALENDAR_ALARM)) ver_q[3] <= !calm_ok;
        end
    end

    assign irq = |(sr_q & imr_q);

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sec_roll;
        run_time && sec_wrap && !wr_at(`OFF_TIME_OF_DAY);
    endsequence
    sequence s_bad_time;
        wr_at(`OFF_TIME_OF_DAY) && !time_ok;
    endsequence

    property p_time_halt;
        time_req_q && !wr_at(`OFF_TIME_OF_DAY) |=> time_q == $past(time_q);
    endproperty
    a_time_halt: assert property (p_time_halt) else $error("time moved while halted");

    property p_cal_halt;
        cal_req_q && !wr_at(`OFF_CALENDAR_DATE) |=> cal_q == $past(cal_q);
    endproperty
    a_cal_halt: assert property (p_cal_halt) else $error("calendar moved while halted");

    property p_sec_roll;
        s_sec_roll |=> time_q[6:0] == 7'h00;
    endproperty
    a_sec_roll: assert property (p_sec_roll) else $error("seconds did not roll to zero");

    property p_min_event;
        s_sec_roll ##0 tsel_q == 2'h0 |=> sr_q[`ST_TIME_EVENT_FLAG] ##1 sr_q[`ST_TIME_EVENT_FLAG] || $past(wr);
    endproperty
    a_min_event: assert property (p_min_event) else $error("minute event flag missing");

    property p_reject;
        s_bad_time |=> ver_q[0] && time_q == $past(time_q);
    endproperty
    a_reject: assert property (p_reject) else $error("invalid time loaded");

    property p_clear;
        wr_at(`OFF_STATUS_CLEAR_COMMAND) && pwdata[`ST_ALARM] && !sr_set[`ST_ALARM] |=> !sr_q[`ST_ALARM];
    endproperty
    a_clear: assert property (p_clear) else $error("alarm flag not cleared");

    property p_mask;
        wr_at(`OFF_IRQ_ENABLE_SET) && pwdata[2] |=> imr_q[2] ##1 (imr_q[2] || $past(wr));
    endproperty
    a_mask: assert property (p_mask) else $error("mask bit not set");

    property p_irq;
        sr_q[`ST_SEC] && imr_q[`ST_SEC] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_zero;
        setup && !pwrite && paddr == `OFF_TIME_OF_DAY |=> prdata[31:23] == 9'h0 && prdata[15] == 1'b0;
    endproperty
    a_zero: assert property (p_zero) else $error("unused time bits read nonzero");
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the bcd clock register file, driven over apb
// assumes zero-wait apb slave and a shortened second of 20 bus cycles
`timescale 1ns/1ns
module tb_top;
    import bcd_clock_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq, ev;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    int err_total = 0;
    int n_checks = 0;

    // short second keeps event scenarios within a few hundred cycles
    bcd_calendar_clock_regs #(.SECOND_CYCLES(20)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    always #5 pclk = ~pclk;

    // ****************************************
    // helpers
    // ****************************************
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            wrap_up();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // poll a status bit with a bounded number of reads
    task automatic wait_st(input int b);
        int n;
        n = 0;
        rd(8'h18);
        while (rv[b] !== 1'b1 && n < 100) begin
            rd(8'h18);
            n++;
        end
        if (n >= 100) begin
            err_total++;
            wrap_up();
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] a[8] = '{8'h08, 8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h28, 8'h2c};
        logic [31:0] e[8] = '{32'h0, 32'h0, 32'h0, 32'h01819819, 32'h0, 32'h01010000, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            rd(a[i]);
            chk("reset value", rv, e[i]);
        end
    endtask

    task automatic t_fields;
        wr(8'h00, 32'hffffffff);
        rd(8'h00);
        chk("control", rv, 32'h00030303);
        wr(8'h04, 32'hffffffff);
        rd(8'h04);
        chk("mode", rv, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
    endtask

    task automatic t_time;
        wr(8'h1c, 32'h1);
        wr(8'h00, 32'h1);
        wait_st(0);
        wr(8'h1c, 32'h1);
        rd(8'h18);
        chk("ack cleared", rv & 32'h1, 32'h0);
        wr(8'h08, 32'h00123456);
        rd(8'h08);
        chk("time load", rv, 32'h00123456);
        repeat (60) @(posedge pclk);
        rd(8'h08);
        chk("time halted", rv, 32'h00123456);
        wr(8'h08, 32'h00000060);
        rd(8'h2c);
        chk("bad second flag", rv & 32'h1, 32'h1);
        wr(8'h08, 32'h00240000);
        rd(8'h08);
        chk("bad hour kept", rv, 32'h00123456);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h00520000);
        rd(8'h08);
        chk("12h pm", rv, 32'h00520000);
        wr(8'h08, 32'h00130000);
        rd(8'h2c);
        chk("12h range", rv & 32'h1, 32'h1);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h00520000);
        rd(8'h2c);
        chk("24h meridiem", rv & 32'h1, 32'h1);
        wr(8'h08, 32'h00235959);
        rd(8'h2c);
        chk("valid clears", rv & 32'h1, 32'h0);
    endtask

    task automatic t_cal;
        wr(8'h00, 32'h2);
        wr(8'h0c, 32'h01819821);
        rd(8'h2c);
        chk("century range", rv & 32'h2, 32'h2);
        wr(8'h0c, 32'h15a20520);
        rd(8'h0c);
        chk("calendar load", rv, 32'h15a20520);
        wr(8'h0c, 32'h01939820);
        rd(8'h0c);
        chk("bad month kept", rv, 32'h15a20520);
        wr(8'h0c, 32'h15020520);
        rd(8'h2c);
        chk("weekday zero", rv & 32'h2, 32'h2);
        wr(8'h00, 32'h0);
    endtask

    // 23:59:58 rolls through minute, hour and midnight but not noon
    task automatic t_event;
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'h1 | (32'(s) << 8));
            wait_st(0);
            wr(8'h08, 32'h00235958);
            wr(8'h1c, 32'h1f);
            wr(8'h00, 32'(s) << 8);
            repeat (70) @(posedge pclk);
            rd(8'h18);
            chk("time event", rv & 32'h8, (s != 3) ? 32'h8 : 32'h0);
        end
    endtask

    task automatic t_irq;
        wr(8'h20, 32'h4);
        rd(8'h28);
        chk("mask set", rv, 32'h4);
        wait_st(2);
        chk("irq high", {31'h0, irq}, 32'h1);
        wr(8'h24, 32'h4);
        rd(8'h28);
        chk("mask clear", rv, 32'h0);
        chk("irq low", {31'h0, irq}, 32'h0);
        wr(8'h1c, 32'h0);
        rd(8'h18);
        chk("zero clear", rv & 32'h4, 32'h4);
        wr(8'h28, 32'h1f);
        rd(8'h28);
        chk("mask read only", rv, 32'h0);
        rd(8'h30);
        chk("unmapped err", {31'h0, ev}, 32'h1);
    endtask

    // jan 31 at 23:59:59 rolls into february on the next second
    task automatic t_calendar_event_flag;
        wr(8'h00, 32'h3);
        wait_st(0);
        wr(8'h0c, 32'h31e10520);
        wr(8'h08, 32'h00235959);
        wr(8'h1c, 32'h1f);
        wr(8'h00, 32'h00010000);
        repeat (25) @(posedge pclk);
        rd(8'h18);
        chk("month event", rv & 32'h10, 32'h10);
        rd(8'h0c);
        chk("month roll", rv, 32'h01220520);
    endtask

    // time held at 10:10:10; disabled fields never block, enabled ones do
    task automatic t_alarm;
        wr(8'h00, 32'h1);
        wait_st(0);
        wr(8'h08, 32'h00101010);
        wr(8'h10, 32'h00002290);
        wr(8'h14, 32'h01050000);
        wr(8'h1c, 32'h2);
        repeat (25) @(posedge pclk);
        rd(8'h18);
        chk("alarm match", rv & 32'h2, 32'h2);
        wr(8'h14, 32'h01850000);
        wr(8'h1c, 32'h2);
        repeat (25) @(posedge pclk);
        rd(8'h18);
        chk("month blocks", rv & 32'h2, 32'h0);
        wr(8'h14, 32'h01050000);
        wr(8'h10, 32'h0000a290);
        wr(8'h1c, 32'h2);
        repeat (25) @(posedge pclk);
        rd(8'h18);
        chk("minute blocks", rv & 32'h2, 32'h0);
        wr(8'h00, 32'h0);
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fields();
        t_time();
        t_cal();
        t_event();
        t_irq();
        t_calendar_event_flag();
        t_alarm();
        wrap_up();
    end

    initial begin
        #900000;
        err_total++;
        wrap_up();
    end
endmodule
